/* abc_backlight_regs.sv */
// Behaviour
// - Upper byte of control one holds commanded brightness, read/write
// - Bit six of control one selects alternate gamma
// - Bit five zero turns backlight fully off on control line
// - Bit four turns display dimming on or off
// - Bit three makes brightness block active or inactive
// - Bits two to one choose preservation mode off/conserve/normal/aggr
// - Bit zero enables adaptive backlight control
// - Enable honoured only while interface select pin is low
// - Control two bits 15-12 set PWM prescale; software picks by pclk
// - Control two bits 11-8 set iteration prescale; software picks
// - Control two low byte is minimum brightness floor for adaptive
module abc_backlight_regs
    import abc_pkg::*;
(
    // Clock and reset
    input  wire logic        mclk_i,
    input  wire logic        rst_n_i,
    // Register port
    input  wire logic [7:0]  addr_i,
    input  wire logic [15:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic [15:0]      rdata_o,
    // Interface select pin
    input  wire logic        if_sel_i,
    // Configuration to brightness logic
    output logic [7:0]       brightness_write_value_o,
    output logic             alt_gamma_select_o,
    output logic             backlight_on_o,
    output logic             dimming_on_o,
    output logic             brightness_block_on_o,
    output logic [1:0]       preservation_mode_o,
    output logic             adaptive_backlight_on_o,
    output logic [3:0]       pwm_prescale_o,
    output logic [3:0]       iteration_prescale_o,
    output logic [7:0]       minimum_brightness_o
);

    // ****************************************************
    // Reset release
    // ****************************************************
    logic rst_n;

    abc_sync u_sync (
        .mclk_i  (mclk_i),
        .rst_n_i (rst_n_i),
        .rst_n_o (rst_n)
    );

    // ****************************************************
    // Decode
    // ****************************************************
    abc_req_t    req;
    logic        hit_one;
    logic        hit_two;
    logic        we_one;
    logic        we_two;
    logic [15:0] q_one;
    logic [15:0] q_two;
    logic [15:0] next_rdata;
    logic        enable_gated;
    abc_cfg_t    cfg;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
        return a == b;
    endfunction

    assign req     = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};
    assign hit_one = hit(req.addr, ADDR_CTRL_ONE);
    assign hit_two = hit(req.addr, ADDR_CTRL_TWO);
    assign we_one  = req.wr & hit_one;
    assign we_two  = req.wr & hit_two;

    // ****************************************************
    // Storage
    // ****************************************************
    abc_reg16 #(
        .RST  (RST_CTRL_ONE),
        .MASK (MASK_CTRL_ONE)
    ) u_one (
        .mclk_i  (mclk_i),
        .rst_n_i (rst_n),
        .we_i    (we_one),
        .wdata_i (req.wdata),
        .q_o     (q_one)
    );

    abc_reg16 #(
        .RST  (RST_CTRL_TWO),
        .MASK (MASK_CTRL_TWO)
    ) u_two (
        .mclk_i  (mclk_i),
        .rst_n_i (rst_n),
        .we_i    (we_two),
        .wdata_i (req.wdata),
        .q_o     (q_two)
    );

    // ****************************************************
    // Field extraction
    // ****************************************************
    assign enable_gated = q_one[ENABLE_BIT] & ~if_sel_i;

    assign cfg = '{
        brightness_write_value:    q_one[BRIGHT_LSB +: 8],
        alt_gamma_select:          q_one[GAMMA_BIT],
        backlight_on:              q_one[BL_BIT],
        dimming_on:                q_one[DIM_BIT],
        brightness_block_on:       q_one[BLOCK_BIT],
        preservation_mode:         abc_mode_t'(q_one[MODE_LSB +: 2]),
        adaptive_backlight_enable: enable_gated,
        pwm_prescale:              q_two[PWM_PRESCALE_LSB +: 4],
        iteration_prescale:        q_two[ITER_PS_LSB +: 4],
        minimum_brightness:        q_two[MIN_LSB +: 8]
    };

    // ****************************************************
    // Read mux
    // ****************************************************
    assign next_rdata = !req.rd ? 16'h0000 :
                        hit_one ? q_one    :
                        hit_two ? q_two    : 16'h0000;

    // ****************************************************
    // Output flops
    // ****************************************************
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            rdata_o                  <= 16'h0000;
            brightness_write_value_o <= 8'h00;
            alt_gamma_select_o       <= 1'b0;
            backlight_on_o           <= 1'b0;
            dimming_on_o             <= 1'b0;
            brightness_block_on_o    <= 1'b0;
            preservation_mode_o      <= 2'h0;
            adaptive_backlight_on_o  <= 1'b0;
            pwm_prescale_o           <= RST_CTRL_TWO[PWM_PRESCALE_LSB +: 4];
            iteration_prescale_o     <= RST_CTRL_TWO[ITER_PS_LSB +: 4];
            minimum_brightness_o     <= 8'h00;
        end else begin
            rdata_o                  <= next_rdata;
            brightness_write_value_o <= cfg.brightness_write_value;
            alt_gamma_select_o       <= cfg.alt_gamma_select;
            backlight_on_o           <= cfg.backlight_on;
            dimming_on_o             <= cfg.dimming_on;
            brightness_block_on_o    <= cfg.brightness_block_on;
            preservation_mode_o      <= cfg.preservation_mode;
            adaptive_backlight_on_o  <= cfg.adaptive_backlight_enable;
            pwm_prescale_o           <= cfg.pwm_prescale;
            iteration_prescale_o     <= cfg.iteration_prescale;
            minimum_brightness_o     <= cfg.minimum_brightness;
        end
    end
endmodule

/* abc_backlight_regs_props.sv */
module abc_chk
    import abc_pkg::*;
(
    // Clock, reset, register port, interface select pin
    input wire logic        mclk_i,
    input wire logic        rst_n_i,
    input wire logic [7:0]  addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic        wr_i,
    input wire logic        rd_i,
    input wire logic [15:0] rdata_o,
    input wire logic        if_sel_i,
    // Configuration
    input wire logic [7:0]  brightness_write_value_o,
    input wire logic        alt_gamma_select_o,
    input wire logic        backlight_on_o,
    input wire logic        dimming_on_o,
    input wire logic        brightness_block_on_o,
    input wire logic [1:0]  preservation_mode_o,
    input wire logic        adaptive_backlight_on_o,
    input wire logic [3:0]  pwm_prescale_o,
    input wire logic [3:0]  iteration_prescale_o,
    input wire logic [7:0]  minimum_brightness_o
);
    // ****
    // Checks
    // ****
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    wire logic w_one = wr_i && addr_i == ADDR_CTRL_ONE;
    wire logic w_two = wr_i && addr_i == ADDR_CTRL_TWO;
    wire logic r_one = rd_i && addr_i == ADDR_CTRL_ONE;
    wire logic r_two = rd_i && addr_i == ADDR_CTRL_TWO;
    AST_BRIGHT: assert property (w_one |-> ##2
        brightness_write_value_o == $past(wdata_i[15:8], 2))
        else $error("brightness not taken");
    AST_FLAGS: assert property (w_one |-> ##2
        {alt_gamma_select_o, backlight_on_o, dimming_on_o,
         brightness_block_on_o} == $past(wdata_i[6:3], 2))
        else $error("flag bits not taken");
    AST_MODE: assert property (w_one |-> ##2
        preservation_mode_o == $past(wdata_i[2:1], 2))
        else $error("mode not taken");
    AST_ENABLE: assert property (w_one ##1 !if_sel_i |=>
        adaptive_backlight_on_o == $past(wdata_i[0], 2))
        else $error("enable not taken");
    AST_GATE: assert property (if_sel_i |=>
        !adaptive_backlight_on_o) else $error("enable not gated");
    AST_PWM: assert property (w_two |-> ##2
        pwm_prescale_o == $past(wdata_i[15:12], 2))
        else $error("pwm prescale not taken");
    AST_ITER: assert property (w_two |-> ##2
        iteration_prescale_o == $past(wdata_i[11:8], 2))
        else $error("iteration prescale not taken");
    AST_MINB: assert property (w_two |-> ##2
        minimum_brightness_o == $past(wdata_i[7:0], 2))
        else $error("minimum not taken");
    AST_RSVD: assert property (w_one ##1 r_one |=>
        rdata_o == ($past(wdata_i, 2) & MASK_CTRL_ONE))
        else $error("readback wrong");
    AST_READ_TWO: assert property (w_two ##1 r_two |=>
        rdata_o == $past(wdata_i, 2))
        else $error("control two readback wrong");
    AST_QUIET: assert property (!(r_one || r_two) |=>
        rdata_o == 16'h0000)
        else $error("read data not quiet");
endmodule
bind abc_backlight_regs abc_chk u_chk (.mclk_i, .rst_n_i, .addr_i,
    .wdata_i, .wr_i, .rd_i, .rdata_o, .if_sel_i, .brightness_write_value_o,
    .alt_gamma_select_o, .backlight_on_o, .dimming_on_o,
    .brightness_block_on_o, .preservation_mode_o, .adaptive_backlight_on_o,
    .pwm_prescale_o, .iteration_prescale_o, .minimum_brightness_o);

/* abc_pkg.sv */
package abc_pkg;

    // ****************************************************
    // Register map
    // ****************************************************
    localparam logic [7:0]  ADDR_CTRL_ONE   = 8'hE9;
    localparam logic [7:0]  ADDR_CTRL_TWO   = 8'hEA;
    localparam logic [15:0] RST_CTRL_ONE    = 16'h0000;
    localparam logic [15:0] RST_CTRL_TWO    = 16'h6900;
    localparam logic [15:0] MASK_CTRL_ONE   = 16'hFF7F;
    localparam logic [15:0] MASK_CTRL_TWO   = 16'hFFFF;

    // ****************************************************
    // Field positions
    // ****************************************************
    localparam int BRIGHT_LSB   = 8;
    localparam int GAMMA_BIT    = 6;
    localparam int BL_BIT       = 5;
    localparam int DIM_BIT      = 4;
    localparam int BLOCK_BIT    = 3;
    localparam int MODE_LSB     = 1;
    localparam int ENABLE_BIT   = 0;
    localparam int PWM_PRESCALE_LSB   = 12;
    localparam int ITER_PS_LSB  = 8;
    localparam int MIN_LSB      = 0;

    // ****************************************************
    // Preservation modes
    // ****************************************************
    typedef enum logic [1:0] {
        ABC_PRES_OFF        = 2'h0,
        ABC_PRES_CONSERVE   = 2'h1,
        ABC_PRES_NORMAL     = 2'h2,
        ABC_PRES_AGGRESSIVE = 2'h3
    } abc_mode_t;

    // ****************************************************
    // Carriers
    // ****************************************************
    typedef struct packed {
        logic [7:0] brightness_write_value;
        logic       alt_gamma_select;
        logic       backlight_on;
        logic       dimming_on;
        logic       brightness_block_on;
        abc_mode_t  preservation_mode;
        logic       adaptive_backlight_enable;
        logic [3:0] pwm_prescale;
        logic [3:0] iteration_prescale;
        logic [7:0] minimum_brightness;
    } abc_cfg_t;

    typedef struct packed {
        logic [7:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } abc_req_t;

endpackage

/* abc_reg16.sv */
module abc_reg16
    import abc_pkg::*;
#(
    parameter logic [15:0] RST  = 16'h0000,
    parameter logic [15:0] MASK = 16'hFFFF
)(
    // Clock and reset
    input  wire logic        mclk_i,
    input  wire logic        rst_n_i,
    // Write port
    input  wire logic        we_i,
    input  wire logic [15:0] wdata_i,
    // Stored value
    output logic [15:0]      q_o
);
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q_o <= RST;
        end else if (we_i) begin
            q_o <= wdata_i & MASK;
        end
    end
endmodule

/* abc_sync.sv */
module abc_sync
    import abc_pkg::*;
(
    // Clock and reset
    input  wire logic mclk_i,
    input  wire logic rst_n_i,
    // Synchronised reset
    output logic      rst_n_o
);
    logic stage;

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            stage   <= 1'b0;
            rst_n_o <= 1'b0;
        end else begin
            stage   <= 1'b1;
            rst_n_o <= stage;
        end
    end
endmodule

/* test_abc_backlight_regs.sv */
module test_abc_backlight_regs
    import abc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk_i = 0, rst_n_i = 0, wr_i = 0, rd_i = 0, if_sel_i = 0;
    logic [7:0]  addr_i = 0;
    logic [15:0] wdata_i = 0, rdata_o;
    logic [7:0]  brightness_write_value_o, minimum_brightness_o;
    logic [3:0]  pwm_prescale_o, iteration_prescale_o;
    logic [1:0]  preservation_mode_o;
    logic alt_gamma_select_o, backlight_on_o, dimming_on_o;
    logic brightness_block_on_o, adaptive_backlight_on_o;
    int n_errors = 0;
    int num_checks = 0;
    wire logic [30:0] cfg = {brightness_write_value_o, alt_gamma_select_o,
        backlight_on_o, dimming_on_o, brightness_block_on_o,
        preservation_mode_o, adaptive_backlight_on_o, pwm_prescale_o,
        iteration_prescale_o, minimum_brightness_o};
    always #50 mclk_i = ~mclk_i;
    abc_backlight_regs DUT (.mclk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i,
        .rd_i, .rdata_o, .if_sel_i, .brightness_write_value_o,
        .alt_gamma_select_o, .backlight_on_o, .dimming_on_o,
        .brightness_block_on_o, .preservation_mode_o,
        .adaptive_backlight_on_o, .pwm_prescale_o, .iteration_prescale_o,
        .minimum_brightness_o);
    // ****
    // Tasks
    // ****
    task automatic chk(input string n, input logic [30:0] e, g);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic drive(input logic w, r, input logic [7:0] a,
                         input logic [15:0] d);
        wr_i    <= w;
        rd_i    <= r;
        addr_i  <= a;
        wdata_i <= d;
        @(posedge mclk_i);
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        drive(1'b1, 1'b0, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        drive(1'b0, 1'b1, a, 16'h0000);
        drive(1'b0, 1'b0, a, 16'h0000);
        chk("rdata", {15'h0000, e}, {15'h0000, rdata_o});
    endtask
    task automatic settle(input logic [15:0] c1, c2);
        repeat (2) drive(1'b0, 1'b0, 8'h00, 16'h0000);
        chk("cfg", {c1[15:8], c1[6:1], c1[0] & ~if_sel_i, c2}, cfg);
    endtask
    task automatic give_verdict;
        if (n_errors == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        repeat (2000) @(posedge mclk_i);
        n_errors++;
        give_verdict;
    end
    // ****
    // Sequence
    // ****
    initial begin
        repeat (16) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        repeat (3) @(posedge mclk_i);
        rd(ADDR_CTRL_ONE, RST_CTRL_ONE);
        rd(ADDR_CTRL_TWO, RST_CTRL_TWO);
        settle(RST_CTRL_ONE, RST_CTRL_TWO);
        wr(ADDR_CTRL_ONE, 16'hFFFF);
        rd(ADDR_CTRL_ONE, 16'hFF7F);
        settle(16'hFF7F, RST_CTRL_TWO);
        for (int m = 0; m < 4; m++) begin
            wr(ADDR_CTRL_ONE, {8'h5A, 5'h00, m[1:0], 1'b1});
            settle({8'h5A, 5'h00, m[1:0], 1'b1}, RST_CTRL_TWO);
        end
        if_sel_i <= 1'b1;
        settle(16'h5A07, RST_CTRL_TWO);
        rd(ADDR_CTRL_ONE, 16'h5A07);
        if_sel_i <= 1'b0;
        settle(16'h5A07, RST_CTRL_TWO);
        wr(ADDR_CTRL_TWO, 16'h7955);
        rd(ADDR_CTRL_TWO, 16'h7955);
        settle(16'h5A07, 16'h7955);
        wr(ADDR_CTRL_TWO, 16'h8BFF);
        wr(8'hE8, 16'hFFFF);
        rd(8'hE8, 16'h0000);
        settle(16'h5A07, 16'h8BFF);
        rst_n_i <= 1'b0;
        repeat (4) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        repeat (3) @(posedge mclk_i);
        rd(ADDR_CTRL_ONE, RST_CTRL_ONE);
        rd(ADDR_CTRL_TWO, RST_CTRL_TWO);
        settle(RST_CTRL_ONE, RST_CTRL_TWO);
        give_verdict;
    end
endmodule
